// file: logic/udwc_pkg.sv
package udwc_pkg;

  // counter width and tap range
  localparam int          POS_W          = 7;
  localparam logic [6:0]  POS_MAX        = 7'h7F;
  localparam logic [6:0]  POS_MIN        = 7'h00;

  // clock and pin timing
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          STORE_DESEL_MS = 20;      // store_deselect_time
  localparam int          NOSTORE_DESEL_US = 1;
  localparam int          STEP_CYCLE_US  = 4;
  localparam int          STORE_DESEL_CYC   = (STORE_DESEL_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          NOSTORE_DESEL_CYC = (NOSTORE_DESEL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          HALF_STEP_CYC     = (STEP_CYCLE_US * 1000 / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // pins driven toward the potentiometer
  typedef struct packed {
    logic select_n;
    logic step_n;
    logic up;
  } udwc_pins_t;

  localparam udwc_pins_t PINS_IDLE = '{select_n: 1'b1, step_n: 1'b1, up: 1'b0};

  // host request
  typedef struct packed {
    logic [6:0] target;
    logic       store;
  } udwc_req_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SELECT = 3'b001,
    ST_LOW    = 3'b010,
    ST_HIGH   = 3'b011,
    ST_DESEL  = 3'b100,
    ST_HOLD   = 3'b101
  } udwc_state_t;

endpackage

// file: logic/udwc_timer.sv
`timescale 1ns/1ns
// down counter: loads a count, flags when expired
module udwc_timer #(
  parameter int CNT_W = 22
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] count,
  output logic                  done
);
  logic [CNT_W-1:0] remain;
  logic [CNT_W-1:0] next_remain;

  // elaboration check: a one-bit count cannot hold a real wait
  if (CNT_W < 2) begin : g_bad_width
    $error("udwc_timer: CNT_W too small");
  end

  // reload wins over counting down
  always_comb begin
    if (load) begin
      next_remain = count;
    end else if (remain != '0) begin
      next_remain = remain - 1'b1;
    end else begin
      next_remain = remain;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= '0;
    end else begin
      remain <= next_remain;
    end
  end

  // done must not depend on load: the sequencer derives load from done
  assign done = (remain == '0);
endmodule

// file: logic/udwc_host.sv
`timescale 1ns/1ns
// Operation
// - to leave without storing, the host holds step low while raising select; a target equal to the tracked tap (or 0 after homing) deselects with step high.
// - direction may change any time while select is low and later steps follow it.
// - the host drives select high from power-up so no accidental store occurs.
// - a step edge coinciding with the select transition moves the wiper, so hosts avoid it.
// - after a storing deselect the host keeps select high for at least 20 ms; a no-store deselect with step high gets only DESEL_WAIT.
module udwc_host
  import udwc_pkg::*;
#(
  parameter int STORE_WAIT = STORE_DESEL_CYC,
  parameter int HALF_STEP  = HALF_STEP_CYC,
  parameter int DESEL_WAIT = NOSTORE_DESEL_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire udwc_pkg::udwc_req_t   req,
  output udwc_pkg::udwc_pins_t       pins,
  output logic [udwc_pkg::POS_W-1:0] position,
  output logic                       known,
  output logic                       busy
);
  import udwc_pkg::*;

  localparam int TW = 22;

  // elaboration checks: every wait must fit the shared TW-bit timer
  if (STORE_WAIT < 1 || STORE_WAIT >= (1 << TW)) begin : g_bad_store
    $error("udwc_host: STORE_WAIT out of range");
  end
  if (DESEL_WAIT < 1 || DESEL_WAIT >= (1 << TW)) begin : g_bad_desel
    $error("udwc_host: DESEL_WAIT out of range");
  end
  if (HALF_STEP < 1 || HALF_STEP >= (1 << TW)) begin : g_bad_step
    $error("udwc_host: HALF_STEP out of range");
  end

  // sequencer state and the request being served
  udwc_state_t       state;
  udwc_state_t       next_state;
  udwc_pins_t        next_pins;
  udwc_req_t         job;
  udwc_req_t         next_job;

  // tracked wiper and the homing sweep after power-up
  logic [POS_W-1:0]  next_position;
  logic              next_known;
  logic              homing;
  logic              next_homing;
  logic [POS_W:0]    steps_left;
  logic [POS_W:0]    next_steps_left;

  // one timer serves strobe halves and deselect holds
  logic              t_load;
  logic [TW-1:0]     t_count;
  logic              t_done;

  udwc_timer #(.CNT_W(TW)) u_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .load    (t_load),
    .count   (t_count),
    .done    (t_done)
  );

  // ready waits for the hold timer, so a new select never cuts a store request's STORE_WAIT short
  assign req_ready = (state == ST_IDLE) && t_done;
  assign busy      = !req_ready;

  // sequencer: select, step toward target, deselect with or without store
  always_comb begin
    next_state      = state;
    next_pins       = pins;
    next_job        = job;
    next_position   = position;
    next_known      = known;
    next_homing     = homing;
    next_steps_left = steps_left;
    t_load          = 1'b0;
    t_count         = '0;
    unique case (state)
      // idle: select and step parked high, up low, take a request once the hold has run out
      ST_IDLE: begin
        next_pins = PINS_IDLE;
        if (req_valid && t_done) begin
          next_job       = req;
          next_pins.select_n = 1'b0;
          // position unknown after power-up: drive to bottom first, saturation makes it safe
          next_homing     = !known;
          next_steps_left = known ? {1'b0, POS_MAX} : {1'b0, POS_MAX} + 8'h01;
          next_state      = ST_SELECT;
          t_load          = 1'b1;
          t_count         = TW'(HALF_STEP);
        end
      end
      // selected, strobe high: set direction, then strobe low or finish
      ST_SELECT: begin
        if (t_done) begin
          if (homing) begin
            next_pins.up = 1'b0;
          end else begin
            next_pins.up = (job.target > position);
          end
          if (!homing && job.target == position) begin
            next_state = ST_DESEL;
          end else begin
            next_state = ST_LOW;
            next_pins.step_n = 1'b0;
            t_load  = 1'b1;
            t_count = TW'(HALF_STEP);
          end
        end
      end
      // strobe low: the device has moved one tap on the falling edge
      ST_LOW: begin
        if (t_done) begin
          // track the device counter, which saturates at the ends
          if (pins.up && position != POS_MAX) begin
            next_position = position + 7'h01;
          end else if (!pins.up && position != POS_MIN) begin
            next_position = position - 7'h01;
          end
          if (homing) begin
            next_steps_left = steps_left - 8'h01;
          end
          if (homing && steps_left == 8'h01) begin
            next_homing   = 1'b0;
            next_position = POS_MIN;
            next_known    = 1'b1;
          end
          // no-store keeps step low through deselect, store needs it high
          if (!homing && next_position == job.target && !job.store) begin
            next_state = ST_DESEL;
          end else begin
            next_pins.step_n = 1'b1;
            next_state = ST_HIGH;
            t_load  = 1'b1;
            t_count = TW'(HALF_STEP);
          end
        end
      end
      // strobe high half of the step cycle
      ST_HIGH: begin
        if (t_done) begin
          next_state = ST_SELECT;
        end
      end
      // deselect: strobe level at select rising picks store or discard
      ST_DESEL: begin
        // step pin is steady here, so no edge coincides with select rising
        next_pins.select_n = 1'b1;
        if (job.store && !pins.step_n) begin
          next_pins.step_n   = 1'b1;
          next_pins.select_n = 1'b0;
          t_load  = 1'b1;
          t_count = TW'(HALF_STEP);
        end else begin
          next_state = ST_HOLD;
          t_load     = 1'b1;
          t_count    = job.store ? TW'(STORE_WAIT) : TW'(DESEL_WAIT);
        end
      end
      // hold select high for the store or no-store deselect time
      ST_HOLD: begin
        next_pins.step_n = 1'b1;
        if (t_done) begin
          next_state = ST_IDLE;
        end
      end
      // unused codes fall back to idle with the pins parked
      default: begin
        next_state = ST_IDLE;
        next_pins  = PINS_IDLE;
      end
    endcase
  end

  // state registers; select and step idle high, up low, from reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      pins       <= PINS_IDLE;
      job        <= '0;
      position   <= POS_MIN;
      known      <= 1'b0;
      homing     <= 1'b0;
      steps_left <= '0;
    end else begin
      state      <= next_state;
      pins       <= next_pins;
      job        <= next_job;
      position   <= next_position;
      known      <= next_known;
      homing     <= next_homing;
      steps_left <= next_steps_left;
    end
  end
endmodule

// file: testbench/udwc_monitor.sv
`timescale 1ns/1ns
module udwc_monitor
  import udwc_pkg::*;
#(
  parameter int STORE_WAIT = 50
) (
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire udwc_pkg::udwc_pins_t pins
);
  logic [15:0] hi_cnt;
  logic        stored;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // cycles since deselect, and whether that deselect committed the tap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= 16'h0000;
      stored <= 1'b0;
    end else begin
      hi_cnt <= pins.select_n ? hi_cnt + ((&hi_cnt) ? 16'h0000 : 16'h0001) : 16'h0000;
      if ($rose(pins.select_n)) stored <= pins.step_n;
    end
  end
  reset_idle_a: assert property ($rose(rst_n) |-> pins.select_n && pins.step_n)
    else $error("pins not idle after reset");
  step_alone_a: assert property ($changed(pins.select_n) |-> $stable(pins.step_n))
    else $error("step moved with select");
  store_hold_a: assert property ($fell(pins.select_n) && stored |-> hi_cnt >= STORE_WAIT)
    else $error("reselected too soon after store");
  step_sel_a: assert property ($fell(pins.step_n) |-> !pins.select_n && !$past(pins.select_n))
    else $error("step while not selected");
  dir_change_a: assert property ($changed(pins.up) |-> $past(pins.step_n))
    else $error("direction moved during strobe low");
  cover property ($rose(pins.select_n) && pins.step_n);
  cover property ($rose(pins.select_n) && !pins.step_n);
  cover property ($changed(pins.up) && !pins.select_n);
endmodule

// file: testbench/udwc_dev_model.sv
`timescale 1ns/1ns
module udwc_dev_model
  import udwc_pkg::*;
#(
  parameter logic [6:0] INIT_NV = 7'h2A
) (
  input  wire udwc_pkg::udwc_pins_t pins,
  input  wire logic                 power_on,
  output logic [6:0]                wiper,
  output logic [6:0]                nv
);
  initial nv = INIT_NV;
  // recall the stored tap whenever power returns
  always @(posedge power_on) wiper = nv;
  // one tap per strobe fall, clamped so the ends never wrap
  always @(negedge pins.step_n) begin
    if (!pins.select_n && power_on) begin
      if (pins.up && wiper != POS_MAX) wiper = wiper + 7'h01;
      else if (!pins.up && wiper != POS_MIN) wiper = wiper - 7'h01;
    end
  end
  // strobe high at deselect commits; strobe low leaves the tap volatile
  always @(posedge pins.select_n) if (pins.step_n && power_on) nv = wiper;
endmodule

// file: testbench/udwc_host_test.sv
`timescale 1ns/1ns
module udwc_host_test;
  import udwc_pkg::*;
  logic        sys_clk, rst_n, req_valid, req_ready, known, busy, power_on, st;
  udwc_req_t   req;
  udwc_pins_t  pins;
  logic [6:0]  position, wiper, nv, exp_nv, cur, tgt;
  logic [13:0] exp_q[$];
  int          num_errors, samples_checked, i;
  udwc_host #(.STORE_WAIT(50), .HALF_STEP(3), .DESEL_WAIT(5)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .pins(pins), .position(position),
    .known(known), .busy(busy));
  udwc_dev_model u_dev (.pins(pins), .power_on(power_on), .wiper(wiper), .nv(nv));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task compare_pos(input logic [6:0] got, input logic [6:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one move request; the expected tap and stored value are noted first
  task send(input logic [6:0] t, input logic s);
    int n;
    @(negedge sys_clk);
    for (n = 0; n < 20000 && req_ready !== 1'b1; n++) @(negedge sys_clk);
    if (s) exp_nv = t;
    exp_q.push_back({t, exp_nv});
    cur = t;
    req_valid = 1'b1;
    req = '{target: t, store: s};
    @(negedge sys_clk);
    req_valid = 1'b0;
    for (n = 0; n < 20000 && busy !== 1'b0; n++) @(negedge sys_clk);
    $display("test done: target %h store %b", t, s);
  endtask
  // completion shows as busy falling; compare against the oldest note
  always @(negedge busy) begin : watch
    logic [13:0] e;
    if (exp_q.size() != 0) begin
      e = exp_q.pop_front();
      compare_pos(wiper, e[13:7]);
      compare_pos(position, e[13:7]);
      compare_pos(nv, e[6:0]);
      compare_pos({6'h00, known}, 7'h01);
    end
  end
  initial begin
    req_valid = 1'b0;
    req = '0;
    power_on = 1'b0;
    rst_n = 1'b0;
    exp_nv = 7'h2A;
    num_errors = 0;
    samples_checked = 0;
    void'($urandom(80561));
    #1 power_on = 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) rst_n = 1'b1;
    send(7'h05, 1'b1);
    send(7'h7F, 1'b0);
    send(7'h7F, 1'b1);
    send(7'h00, 1'b0);
    for (i = 0; i < 3; i++) begin
      tgt = 7'($urandom);
      st = 1'($urandom);
      // an unchanged tap without store would deselect with strobe high
      if (tgt == cur) st = 1'b1;
      send(tgt, st);
    end
    @(negedge sys_clk) power_on = 1'b0;
    #20 power_on = 1'b1;
    #1 compare_pos(wiper, exp_nv);
    $display("test done: power cycle");
    end_sim;
  end
  // hang guard well past the longest expected run
  initial begin
    #400000;
    num_errors++;
    end_sim;
  end
endmodule
bind udwc_host udwc_monitor #(.STORE_WAIT(STORE_WAIT)) u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins));
